// >>> verilog/wtqe_defines.vh
`ifndef WTQE_DEFINES_VH
`define WTQE_DEFINES_VH

// ==========================================================
// register byte offsets on the apb bus
`define WTQE_REG_CTRL 12'h000
`define WTQE_REG_STATUS 12'h004
`define WTQE_REG_TABLE_BASE 12'h008
`define WTQE_REG_DATA_IN 12'h00C
`define WTQE_REG_FILL_COUNT 12'h010
`define WTQE_REG_PATTERN 12'h014
`define WTQE_REG_CMP 12'h018
`define WTQE_REG_SEARCH_INDEX 12'h01C
`define WTQE_REG_RESULT 12'h020
`define WTQE_REG_MEM_ADDR 12'h024
`define WTQE_REG_MEM_DATA 12'h028

// ==========================================================
// operation codes written to the control register
`define WTQE_OP_NONE 3'h0
`define WTQE_OP_APPEND 3'h1
`define WTQE_OP_FIFO 3'h2
`define WTQE_OP_LIFO 3'h3
`define WTQE_OP_FILL 3'h4
`define WTQE_OP_SEARCH 3'h5

// ==========================================================
// compare codes for the search
`define WTQE_CMP_EQ 3'h1
`define WTQE_CMP_NE 3'h2
`define WTQE_CMP_LT 3'h3
`define WTQE_CMP_GT 3'h4

// ==========================================================
// error codes
`define WTQE_ERR_NONE 16'h0000
`define WTQE_ERR_INDIRECT 16'h0006
`define WTQE_ERR_RANGE 16'h0091

// ==========================================================
// table layout and limits
`define WTQE_OFS_COUNT 17'h00001
`define WTQE_OFS_DATA 17'h00002
`define WTQE_MAX_ENTRIES 16'h0064
`define WTQE_FILL_MIN 16'h0001
`define WTQE_FILL_MAX 16'h00FF

// ==========================================================
// status register bit positions
`define WTQE_ST_OK 0
`define WTQE_ST_OVF 1
`define WTQE_ST_EMPTY 2
`define WTQE_ST_BUSY 3
`define WTQE_ST_ERR_LO 16

`endif

// >>> verilog/wtqe_engine.v
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`include "wtqe_defines.vh"

// What this block does
// - table: max word, count word, data
// - append writes after last entry, count+1
// - at most one hundred data entries
// - append on full table: overflow, fail
// - fifo pops oldest, shifts rest, count-1
// - lifo pops newest, count-1, rest stay
// - removal from empty table: empty, fail
// - bad address 0006, range 0091, fail
// - fill writes value into consecutive words
// - fill count 1..255, else range error
// - search compares: eq, ne, lt, gt
// - hit leaves index; miss sets count
// - search entries numbered zero to ninety-nine
module wtqe_engine #(
  parameter AW = 8
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // operation status
  output reg enable_out_ok,
  output reg overflow_flag,
  output reg empty_flag,
  output reg busy
);

  // ==========================================================
  // state encoding
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_HDR = 4'h2;
  localparam [3:0] S_LOOP = 4'h4;
  localparam [3:0] S_FIN = 4'h8;
  localparam [16:0] MEM_WORDS = 17'h00001 << AW;

  // ==========================================================
  // storage and registers
  reg [15:0] mem [0:(1<<AW)-1];
  reg [3:0] state_r;
  reg [2:0] op_r;
  reg [15:0] table_base_r;
  reg [15:0] data_in_r;
  reg [15:0] fill_count_r;
  reg [15:0] match_pattern_r;
  reg [2:0] cmp_r;
  reg [15:0] search_index_r;
  reg [15:0] result_r;
  reg [15:0] mem_addr_r;
  reg [15:0] err_r;
  reg [15:0] cnt_r;
  reg [15:0] rem_r;
  reg [AW-1:0] ptr_r;

  // ==========================================================
  // table address arithmetic, one extra bit to see overruns
  wire [16:0] b17 = {1'b0, table_base_r};
  wire [16:0] a_cnt = b17 + `WTQE_OFS_COUNT;
  wire [16:0] a_dat0 = b17 + `WTQE_OFS_DATA;
  wire [15:0] max_length_word = mem[b17[AW-1:0]];
  wire [15:0] entry_count_word = mem[a_cnt[AW-1:0]];
  wire [16:0] a_app = a_dat0 + {1'b0, entry_count_word};
  wire [16:0] a_lifo = a_cnt + {1'b0, entry_count_word};
  wire [16:0] a_srch = a_cnt + {1'b0, rem_r};
  wire [AW-1:0] ptr_inc = ptr_r + {{(AW-1){1'b0}}, 1'b1};
  wire [15:0] entry = mem[a_srch[AW-1:0]];

  // the whole table or fill span must lie inside the memory before anything moves
  wire tbl_bad = (a_cnt + {1'b0, max_length_word}) >= MEM_WORDS;
  wire srch_bad = (b17 + {1'b0, max_length_word}) >= MEM_WORDS;
  wire fill_bad = (b17 + {1'b0, fill_count_r}) > MEM_WORDS;
  wire tbl_rng = (max_length_word > `WTQE_MAX_ENTRIES) |
                 (entry_count_word > max_length_word);
  wire srch_rng = (max_length_word > `WTQE_MAX_ENTRIES) |
                  (cmp_r < `WTQE_CMP_EQ) | (cmp_r > `WTQE_CMP_GT);
  wire fill_rng = (fill_count_r < `WTQE_FILL_MIN) |
                  (fill_count_r > `WTQE_FILL_MAX);

  // ==========================================================
  // operand checks, indirect address takes priority over range except for fill, where range is checked first
  reg [15:0] chk_err;
  always @* begin
    chk_err = `WTQE_ERR_NONE;
    case (op_r)
      `WTQE_OP_APPEND, `WTQE_OP_FIFO, `WTQE_OP_LIFO: begin
        if (tbl_bad) chk_err = `WTQE_ERR_INDIRECT;
        else if (tbl_rng) chk_err = `WTQE_ERR_RANGE;
      end
      `WTQE_OP_FILL: begin
        if (fill_rng) chk_err = `WTQE_ERR_RANGE;
        else if (fill_bad) chk_err = `WTQE_ERR_INDIRECT;
      end
      `WTQE_OP_SEARCH: begin
        if (srch_bad) chk_err = `WTQE_ERR_INDIRECT;
        else if (srch_rng) chk_err = `WTQE_ERR_RANGE;
      end
      default: chk_err = `WTQE_ERR_NONE;
    endcase
  end

  // ==========================================================
  // search compare, patterns are signed words
  reg hit;
  always @* begin
    case (cmp_r)
      `WTQE_CMP_EQ: hit = (entry == match_pattern_r);
      `WTQE_CMP_NE: hit = (entry != match_pattern_r);
      `WTQE_CMP_LT: hit = ($signed(entry) < $signed(match_pattern_r));
      `WTQE_CMP_GT: hit = ($signed(entry) > $signed(match_pattern_r));
      default: hit = 1'b0;
    endcase
  end

  // ==========================================================
  // apb read mux and error decode
  wire acc_first = psel & penable & ~pready;
  wire commit = psel & penable & pready & ~pslverr;
  wire op_ok = (pwdata[2:0] != `WTQE_OP_NONE) & (pwdata[2:0] <= `WTQE_OP_SEARCH);
  reg [31:0] rd_mux;
  reg bus_err;
  always @* begin
    rd_mux = 32'h00000000;
    bus_err = 1'b0;
    if (paddr == `WTQE_REG_CTRL) begin
      rd_mux = {29'h00000000, op_r};
      bus_err = pwrite & ~op_ok;
    end else if (paddr == `WTQE_REG_STATUS) begin
      rd_mux = {err_r, 12'h000, busy, empty_flag, overflow_flag, enable_out_ok};
      bus_err = pwrite;
    end else if (paddr == `WTQE_REG_TABLE_BASE) begin
      rd_mux = {16'h0000, table_base_r};
    end else if (paddr == `WTQE_REG_DATA_IN) begin
      rd_mux = {16'h0000, data_in_r};
    end else if (paddr == `WTQE_REG_FILL_COUNT) begin
      rd_mux = {16'h0000, fill_count_r};
    end else if (paddr == `WTQE_REG_PATTERN) begin
      rd_mux = {16'h0000, match_pattern_r};
    end else if (paddr == `WTQE_REG_CMP) begin
      rd_mux = {29'h00000000, cmp_r};
    end else if (paddr == `WTQE_REG_SEARCH_INDEX) begin
      rd_mux = {16'h0000, search_index_r};
    end else if (paddr == `WTQE_REG_RESULT) begin
      rd_mux = {16'h0000, result_r};
      bus_err = pwrite;
    end else if (paddr == `WTQE_REG_MEM_ADDR) begin
      rd_mux = {16'h0000, mem_addr_r};
    end else if (paddr == `WTQE_REG_MEM_DATA) begin
      rd_mux = {16'h0000, mem[mem_addr_r[AW-1:0]]};
    end else begin
      bus_err = 1'b1;
    end
    // writes during an operation would disturb operands mid-flight
    if (pwrite & busy) bus_err = 1'b1;
  end

  // ==========================================================
  // bus slave and operation sequencer
  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      enable_out_ok <= 1'b0;
      overflow_flag <= 1'b0;
      empty_flag <= 1'b0;
      busy <= 1'b0;
      state_r <= S_IDLE;
      op_r <= `WTQE_OP_NONE;
      table_base_r <= 16'h0000;
      data_in_r <= 16'h0000;
      fill_count_r <= 16'h0000;
      match_pattern_r <= 16'h0000;
      cmp_r <= `WTQE_CMP_EQ;
      search_index_r <= 16'h0000;
      result_r <= 16'h0000;
      mem_addr_r <= 16'h0000;
      err_r <= `WTQE_ERR_NONE;
      cnt_r <= 16'h0000;
      rem_r <= 16'h0000;
      ptr_r <= {AW{1'b0}};
    end else begin
      // every access waits exactly one cycle
      pready <= acc_first;
      if (acc_first) begin
        prdata <= rd_mux;
        pslverr <= bus_err;
      end
      if (commit & pwrite) begin
        if (paddr == `WTQE_REG_CTRL) begin
          op_r <= pwdata[2:0];
          state_r <= S_HDR;
          busy <= 1'b1;
          enable_out_ok <= 1'b0;
          overflow_flag <= 1'b0;
          empty_flag <= 1'b0;
          err_r <= `WTQE_ERR_NONE;
        end else if (paddr == `WTQE_REG_TABLE_BASE) begin
          table_base_r <= pwdata[15:0];
        end else if (paddr == `WTQE_REG_DATA_IN) begin
          data_in_r <= pwdata[15:0];
        end else if (paddr == `WTQE_REG_FILL_COUNT) begin
          fill_count_r <= pwdata[15:0];
        end else if (paddr == `WTQE_REG_PATTERN) begin
          match_pattern_r <= pwdata[15:0];
        end else if (paddr == `WTQE_REG_CMP) begin
          cmp_r <= pwdata[2:0];
        end else if (paddr == `WTQE_REG_SEARCH_INDEX) begin
          search_index_r <= pwdata[15:0];
        end else if (paddr == `WTQE_REG_MEM_ADDR) begin
          mem_addr_r <= pwdata[15:0];
        end else if (paddr == `WTQE_REG_MEM_DATA) begin
          mem[mem_addr_r[AW-1:0]] <= pwdata[15:0];
        end
      end
      case (state_r)
        S_HDR: begin
          if (chk_err != `WTQE_ERR_NONE) begin
            err_r <= chk_err;
            state_r <= S_IDLE;
            busy <= 1'b0;
          end else begin
            case (op_r)
              `WTQE_OP_APPEND: begin
                if (entry_count_word >= max_length_word) begin
                  overflow_flag <= 1'b1;
                  state_r <= S_IDLE;
                  busy <= 1'b0;
                end else begin
                  mem[a_app[AW-1:0]] <= data_in_r;
                  cnt_r <= entry_count_word + 16'h0001;
                  state_r <= S_FIN;
                end
              end
              `WTQE_OP_FIFO, `WTQE_OP_LIFO: begin
                if (entry_count_word == 16'h0000) begin
                  empty_flag <= 1'b1;
                  state_r <= S_IDLE;
                  busy <= 1'b0;
                end else begin
                  cnt_r <= entry_count_word - 16'h0001;
                  if (op_r == `WTQE_OP_FIFO) begin
                    result_r <= mem[a_dat0[AW-1:0]];
                    ptr_r <= a_dat0[AW-1:0];
                    rem_r <= entry_count_word - 16'h0001;
                    state_r <= (entry_count_word == 16'h0001) ? S_FIN : S_LOOP;
                  end else begin
                    result_r <= mem[a_lifo[AW-1:0]];
                    state_r <= S_FIN;
                  end
                end
              end
              `WTQE_OP_FILL: begin
                ptr_r <= b17[AW-1:0];
                rem_r <= fill_count_r;
                state_r <= S_LOOP;
              end
              default: begin
                cnt_r <= max_length_word; // count word sits at the search base
                rem_r <= search_index_r;
                state_r <= S_LOOP;
              end
            endcase
          end
        end
        S_LOOP: begin
          case (op_r)
            `WTQE_OP_FIFO: begin
              mem[ptr_r] <= mem[ptr_inc];
              ptr_r <= ptr_inc;
              rem_r <= rem_r - 16'h0001;
              if (rem_r == 16'h0001) state_r <= S_FIN;
            end
            `WTQE_OP_FILL: begin
              mem[ptr_r] <= data_in_r;
              ptr_r <= ptr_inc;
              rem_r <= rem_r - 16'h0001;
              if (rem_r == 16'h0001) begin
                enable_out_ok <= 1'b1;
                state_r <= S_IDLE;
                busy <= 1'b0;
              end
            end
            default: begin
              if (rem_r >= cnt_r) begin
                search_index_r <= cnt_r;
                enable_out_ok <= 1'b1;
                state_r <= S_IDLE;
                busy <= 1'b0;
              end else if (hit) begin
                search_index_r <= rem_r;
                enable_out_ok <= 1'b1;
                state_r <= S_IDLE;
                busy <= 1'b0;
              end else begin
                rem_r <= rem_r + 16'h0001;
              end
            end
          endcase
        end
        S_FIN: begin
          // count is written last so a pop never shows a stale tail
          mem[a_cnt[AW-1:0]] <= cnt_r;
          enable_out_ok <= 1'b1;
          state_r <= S_IDLE;
          busy <= 1'b0;
        end
        // idle must not override the start taken by the bus write above
        S_IDLE: ;
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule // wtqe_engine

// >>> dv/wtqe_props.sv
`timescale 1ns/1ps
// ====
// port-level checks for the table engine
module wtqe_props (
  // clock and reset
  input wire clk,
  input wire rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // status
  input wire enable_out_ok,
  input wire overflow_flag,
  input wire empty_flag,
  input wire busy
);
  // accepted control write; a refused one must not start anything
  wire done_w = psel && penable && pready && pwrite;
  wire start = done_w && paddr == 12'h000 && !pslverr;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ready_pulse: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("ready not a single pulse");
  a_start_busy: assert property (start |=> busy && !enable_out_ok && !overflow_flag && !empty_flag)
    else $error("start did not clear flags");
  a_busy_ends: assert property ($rose(busy) |-> ##[1:300] !busy)
    else $error("operation never finished");
  a_ovf_fails: assert property (overflow_flag |-> !enable_out_ok && !empty_flag)
    else $error("overflow with success");
  a_empty_fails: assert property (empty_flag |-> !enable_out_ok && !overflow_flag)
    else $error("empty with success");
  a_ok_idle: assert property (enable_out_ok |-> !busy)
    else $error("success while busy");
  a_flags_hold: assert property (!busy && !start |=>
    $stable({enable_out_ok, overflow_flag, empty_flag}))
    else $error("flags moved while idle");
  a_ro_refused: assert property (done_w && paddr == 12'h004 |-> pslverr)
    else $error("status write accepted");
  a_busy_refused: assert property (done_w && busy |-> pslverr)
    else $error("write accepted while busy");
endmodule // wtqe_props

bind wtqe_engine wtqe_props u_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .enable_out_ok(enable_out_ok), .overflow_flag(overflow_flag),
  .empty_flag(empty_flag), .busy(busy));

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`include "wtqe_defines.vh"
// ====
// self-checking bench for the table engine
module tb_top;
  reg clk = 0;
  reg rst = 1;
  reg psel = 0;
  reg penable = 0;
  reg pwrite = 0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  wire [31:0] prdata;
  wire pready, pslverr, ok, ovf, emp, busy;
  int err_total = 0;
  int total_checks = 0;
  logic [32:0] exp_q[$];
  string nm_q[$];
  logic [32:0] e;
  logic [15:0] v [0:3];
  bit [11:0] sc [6] = '{12'h100, 12'h112, 12'h134, 12'h201, 12'h303, 12'h401};
  always #2.5 clk = ~clk;

  wtqe_engine dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enable_out_ok(ok), .overflow_flag(ovf), .empty_flag(emp), .busy(busy));

  task check(input string nm, input [32:0] seen, input [32:0] want);
    total_checks++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, want, seen);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // compare at the edge where pready is sampled high; write data is not read back
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      check(nm_q.pop_front(), {pslverr, pwrite ? e[31:0] : prdata}, e);
    end
  end

  task xfer(input bit w, input [11:0] a, input [31:0] d, input [32:0] x, input string nm);
    int n;
    exp_q.push_back(x);
    nm_q.push_back(nm);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin err_total++; wrap_up; end
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask

  task wr(input [11:0] a, input [31:0] d); xfer(1, a, d, 33'h0, "write"); endtask
  task rd(input [11:0] a, input [15:0] x, input string nm); xfer(0, a, 0, {17'h0, x}, nm); endtask
  task mw(input [7:0] a, input [15:0] d);
    wr(`WTQE_REG_MEM_ADDR, {24'h0, a});
    wr(`WTQE_REG_MEM_DATA, {16'h0, d});
  endtask
  task mr(input [7:0] a, input [15:0] x);
    wr(`WTQE_REG_MEM_ADDR, {24'h0, a});
    rd(`WTQE_REG_MEM_DATA, x, "word");
  endtask
  // bounded wait for the engine to go idle, then check the whole status word
  task fin(input [31:0] st);
    int n;
    n = 0;
    do begin @(negedge clk); n++; end while (busy !== 1'b0 && n < 1000);
    if (n >= 1000) begin err_total++; wrap_up; end
    check("flag pins", {29'h0, busy, emp, ovf, ok}, {29'h0, st[3:0]});
    @(posedge clk);
    xfer(0, `WTQE_REG_STATUS, 0, {1'b0, st}, "status");
  endtask
  task op(input [2:0] c, input [31:0] st); wr(`WTQE_REG_CTRL, {29'h0, c}); fin(st); endtask

  initial begin
    int i;
    i = $urandom(49);
    for (i = 0; i < 4; i++) v[i] = 16'($urandom);
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(`WTQE_REG_CMP, 16'h1, "cmp reset");
    mw(8'h10, 16'h3);
    mw(8'h11, 16'h0);
    wr(`WTQE_REG_TABLE_BASE, 32'h10);
    for (i = 0; i < 3; i++) begin
      wr(`WTQE_REG_DATA_IN, {16'h0, v[i]});
      op(`WTQE_OP_APPEND, 32'h1);
    end
    op(`WTQE_OP_APPEND, 32'h2);
    mr(8'h11, 16'h3);
    mr(8'h14, v[2]);
    $display("append test done");
    op(`WTQE_OP_LIFO, 32'h1);
    rd(`WTQE_REG_RESULT, v[2], "popped");
    op(`WTQE_OP_FIFO, 32'h1);
    rd(`WTQE_REG_RESULT, v[0], "popped");
    mr(8'h12, v[1]);
    mr(8'h11, 16'h1);
    op(`WTQE_OP_FIFO, 32'h1);
    op(`WTQE_OP_FIFO, 32'h4);
    op(`WTQE_OP_LIFO, 32'h4);
    mr(8'h11, 16'h0);
    $display("removal test done");
    xfer(1, `WTQE_REG_STATUS, 0, {1'b1, 32'h0}, "ro write");
    xfer(1, 12'h0FC, 0, {1'b1, 32'h0}, "unmapped");
    mw(8'hFF, 16'h0);
    wr(`WTQE_REG_TABLE_BASE, 32'hFF);
    op(`WTQE_OP_APPEND, 32'h00060000);
    wr(`WTQE_REG_TABLE_BASE, 32'h0);
    wr(`WTQE_REG_DATA_IN, {16'h0, v[3]});
    wr(`WTQE_REG_FILL_COUNT, 32'h0);
    op(`WTQE_OP_FILL, 32'h00910000);
    wr(`WTQE_REG_FILL_COUNT, 32'h100);
    op(`WTQE_OP_FILL, 32'h00910000);
    wr(`WTQE_REG_FILL_COUNT, 32'hFF);
    wr(`WTQE_REG_CTRL, {29'h0, `WTQE_OP_FILL});
    xfer(1, `WTQE_REG_DATA_IN, 0, {1'b1, 32'h0}, "busy write");
    fin(32'h1);
    mr(8'h00, v[3]);
    mr(8'hFE, v[3]);
    mr(8'hFF, 16'h0);
    $display("fill test done");
    mw(8'h81, 16'h4);
    mw(8'h82, 16'h5);
    mw(8'h83, 16'h9);
    mw(8'h84, 16'h5);
    mw(8'h85, 16'hFFFE);
    wr(`WTQE_REG_TABLE_BASE, 32'h81);
    wr(`WTQE_REG_PATTERN, 32'h5);
    // each entry: compare code, start index, expected index
    for (i = 0; i < 6; i++) begin
      wr(`WTQE_REG_CMP, {28'h0, sc[i][11:8]});
      wr(`WTQE_REG_SEARCH_INDEX, {28'h0, sc[i][7:4]});
      op(`WTQE_OP_SEARCH, 32'h1);
      rd(`WTQE_REG_SEARCH_INDEX, {12'h0, sc[i][3:0]}, "index");
    end
    wr(`WTQE_REG_CMP, 32'h0);
    op(`WTQE_OP_SEARCH, 32'h00910000);
    $display("search test done");
    wrap_up;
  end
endmodule // tb_top
